// ==== dmag_pkg.sv ====
package dmag_pkg;
	// Address shape: four bank bits over an eight-bit offset
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;
	localparam logic [3:0] BANK_LOW = 4'h0;
	localparam logic [3:0] BANK_MAX_LOW = 4'h3;
	localparam logic [3:0] BANK_PERIPH = 4'hf;
	localparam logic [11:0] RAM_TOP = 12'h3ff;
	localparam logic [11:0] PERIPH_BASE = 12'hf80;
	localparam logic [11:0] ADDR_ODD = 12'h001;
	// Fixed and port bit-area windows, by upper operand nibble or top two bits
	localparam logic [3:0] FMEM_IRQ_NIB = 4'hb;
	localparam logic [3:0] FMEM_PORT_NIB = 4'hf;
	localparam logic [1:0] PMEM_TOP_BITS = 2'h3;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PTR = 8'h04;
	localparam logic [7:0] REG_SP = 8'h08;
	localparam logic [7:0] REG_CMD = 8'h0c;
	localparam logic [7:0] REG_RES = 8'h10;
	// Field positions
	localparam int CTRL_BE_POS = 0;
	localparam int CTRL_BS_POS = 4;
	localparam int CTRL_SBS_POS = 8;
	localparam int PTR_L_POS = 0;
	localparam int PTR_H_POS = 4;
	localparam int PTR_E_POS = 8;
	localparam int PTR_D_POS = 12;
	localparam int CMD_MODE_POS = 0;
	localparam int CMD_OP_POS = 4;
	localparam int CMD_BIT_POS = 12;
	localparam int CMD_INS_POS = 16;
	localparam int RES_BIT_POS = 12;
	localparam int RES_PAIR_POS = 14;
	localparam int RES_RAM_POS = 15;
	localparam int RES_PER_POS = 16;
	localparam int RES_ERR_POS = 17;
	localparam int RES_DONE_POS = 18;
	// Reset values and bus answers
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		MODE_DIR1 = 4'h0, MODE_DIR4 = 4'h1, MODE_DIR8 = 4'h2,
		MODE_HL = 4'h3, MODE_HL_INC = 4'h4, MODE_HL_DEC = 4'h5,
		MODE_DE = 4'h6, MODE_DL = 4'h7, MODE_HL8 = 4'h8,
		MODE_FMEM = 4'h9, MODE_PMEM = 4'ha, MODE_HTOP = 4'hb,
		MODE_STACK = 4'hc
	} dmag_mode_t;

	typedef enum logic [3:0] {
		INS_SET = 4'h0, INS_CLR = 4'h1, INS_SKT = 4'h2, INS_SKF = 4'h3,
		INS_MOV = 4'h4, INS_XCH = 4'h5, INS_INCREMENT_SKIP_INSTR = 4'h6, INS_IN = 4'h7,
		INS_OUT = 4'h8, INS_OTHER = 4'hf
	} dmag_instr_t;

	// Instructions allowed per direct mode, one bit per code
	localparam logic [15:0] DIR1_INS = 16'h000f;
	localparam logic [15:0] DIR4_INS = 16'h01f0;
	localparam logic [15:0] DIR8_INS = 16'h01b0;

	function automatic logic bank_ok(input logic [3:0] b);
		return (b <= BANK_MAX_LOW) || (b == BANK_PERIPH);
	endfunction
endpackage

// ==== dmag_calc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dmag_calc_if;
	import dmag_pkg::*;
	dmag_mode_t  mode;
	dmag_instr_t instr;
	logic [7:0]  operand;
	logic [1:0]  bitn;
	logic        bank_en;
	logic [3:0]  bank_sel;
	logic [1:0]  stack_bank_select;
	logic [3:0]  l, h, d, e;
	logic [7:0]  sp;
	logic [11:0] addr;
	logic [1:0]  bitsel;
	logic        pair;
	logic        bad;
	modport calc (input mode, instr, operand, bitn, bank_en, bank_sel, stack_bank_select,
		l, h, d, e, sp, output addr, bitsel, pair, bad);
	modport host (output mode, instr, operand, bitn, bank_en, bank_sel, stack_bank_select,
		l, h, d, e, sp, input addr, bitsel, pair, bad);
endinterface
`default_nettype wire

// ==== dmag_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmag_calc import dmag_pkg::*; (
	// Request in, address out
	dmag_calc_if.calc c
);
	logic [3:0] dbank;
	logic [3:0] abank;

	function automatic logic ins_in(input dmag_instr_t i, input logic [15:0] m);
		return m[i];
	endfunction

	// One address per mode; purely combinational so the top decides timing
	always_comb begin
		dbank = c.bank_en ? c.bank_sel : (c.operand[7] ? BANK_PERIPH : BANK_LOW);
		abank = c.bank_en ? c.bank_sel : BANK_LOW;
		c.addr = {abank, c.h, c.l};
		c.bitsel = c.bitn;
		c.pair = 1'b0;
		c.bad = 1'b0;
		case (c.mode)
			MODE_DIR1: begin
				c.addr = {dbank, c.operand};
				c.bad = !ins_in(c.instr, DIR1_INS);
			end
			MODE_DIR4: begin
				c.addr = {dbank, c.operand};
				c.bad = !ins_in(c.instr, DIR4_INS);
			end
			MODE_DIR8: begin
				c.addr = {dbank, c.operand};
				c.pair = 1'b1;
				c.bad = !ins_in(c.instr, DIR8_INS) || c.operand[0];
			end
			MODE_HL, MODE_HL_INC, MODE_HL_DEC: c.addr = {abank, c.h, c.l};
			MODE_DE: c.addr = {BANK_LOW, c.d, c.e};
			MODE_DL: c.addr = {BANK_LOW, c.d, c.l};
			MODE_HL8: begin
				c.addr = {abank, c.h, c.l[3:1], 1'b0};
				c.pair = 1'b1;
			end
			MODE_FMEM: begin
				c.addr = {BANK_PERIPH, c.operand};
				c.bad = !(c.operand[7:4] == FMEM_IRQ_NIB || c.operand[7:4] == FMEM_PORT_NIB);
			end
			MODE_PMEM: begin
				c.addr = {BANK_PERIPH, c.operand[7:2], c.l[3:2]};
				c.bitsel = c.l[1:0];
				c.bad = c.operand[7:6] != PMEM_TOP_BITS;
			end
			MODE_HTOP: c.addr = {abank, c.h, c.operand[3:0]};
			MODE_STACK: c.addr = {2'b00, c.stack_bank_select, c.sp};
			default: c.bad = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// ==== dmag_region.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmag_region import dmag_pkg::*; (
	// Address in
	input  wire logic [11:0] addr,
	// Target decode out
	output logic             ram_hit,
	output logic             periph_hit
);
	// Gap between RAM and peripherals answers to neither target
	always_comb begin
		ram_hit = addr <= RAM_TOP;
		periph_hit = addr >= PERIPH_BASE;
	end
endmodule
`default_nettype wire

// ==== dmag_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Direct, flag clear, low operand: bank 0
// - Direct, flag clear, high operand: bank 15
// - Direct, flag set: bank from select register
// - 1-bit direct only for four bit instructions
// - 4-bit direct for five instructions, one nibble
// - 8-bit direct: even operand, nibble pair
// - 8-bit direct only for four instructions
// - Primary pointer indirect uses flag AND select
// - Step bottom pointer after the access
// - Second and third pointers always bank 0
// - Primary byte indirect ignores pointer bit 0
// - Fixed bit area: interrupt and port nibbles
// - Port bit area: operand six bits, pointer bits
// - Pointer-top bit: bank, top nibble, operand
// - Stack: pointer within banks 0 to 3
// - Thirteen addressing modes chosen by the command mode field
// - Address is twelve bits, bank on top
// - Bank select accepts 0, 1, 2, 3, 15
// - RAM below 400, peripherals from F80
module dmag_top import dmag_pkg::*; (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var logic         s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var logic         s_axi_wready,
	output var logic [1:0]   s_axi_bresp,
	output var logic         s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var logic         s_axi_arready,
	output var logic [31:0]  s_axi_rdata,
	output var logic [1:0]   s_axi_rresp,
	output var logic         s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Data memory access
	output var logic [11:0]  mem_addr_q,
	output var logic [11:0]  mem_addr_odd_q,
	output var logic [1:0]   mem_bit_q,
	output var logic         mem_pair_q,
	output var logic         mem_strobe_q,
	output var logic         ram_sel_q,
	output var logic         periph_sel_q,
	output var logic         mem_err_q
);
	dmag_calc_if cif ();
	logic        awv_q, awv_d, wv_q, wv_d, awr_q, awr_d, wr_q, wr_d;
	logic [7:0]  awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0]  ws_q, ws_d;
	logic        bv_q, bv_d, do_wr;
	logic [1:0]  br_q, br_d;
	logic        arr_q, arr_d, rv_q, rv_d;
	logic [31:0] rd_q, rd_d;
	logic [1:0]  rr_q, rr_d;
	logic        be_q, be_d, go_q, go_d, done_q, done_d;
	logic [3:0]  bs_q, bs_d, l_q, l_d, h_q, h_d, e_q, e_d, d_q, d_d;
	logic [1:0]  sbs_q, sbs_d, bitn_q, bitn_d;
	logic [7:0]  sp_q, sp_d, op_q, op_d;
	dmag_mode_t  mode_q, mode_d;
	dmag_instr_t ins_q, ins_d;
	logic [11:0] ma_d, mo_d;
	logic [1:0]  mb_d;
	logic        mp_d, ms_d, rs_d, ps_d, me_d, ram_hit, per_hit;

	function automatic logic lane(input logic [3:0] s, input int pos);
		return s[pos / 8];
	endfunction

	assign cif.mode = mode_q;
	assign cif.instr = ins_q;
	assign cif.operand = op_q;
	assign cif.bitn = bitn_q;
	assign cif.bank_en = be_q;
	assign cif.bank_sel = bs_q;
	assign cif.stack_bank_select = sbs_q;
	assign cif.l = l_q;
	assign cif.h = h_q;
	assign cif.d = d_q;
	assign cif.e = e_q;
	assign cif.sp = sp_q;

	dmag_calc u_calc (
		.c (cif.calc)
	);

	dmag_region u_region (
		.addr       (cif.addr),
		.ram_hit    (ram_hit),
		.periph_hit (per_hit)
	);

	// Write channels: address and data held apart, either may come first
	assign do_wr = awv_q && wv_q && !bv_q;
	always_comb begin
		awv_d = awv_q;
		awa_d = awa_q;
		wv_d = wv_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		if (s_axi_awvalid && awr_q) begin
			awv_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_q) begin
			wv_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (do_wr) begin
			awv_d = 1'b0;
			wv_d = 1'b0;
			bv_d = 1'b1;
			if (awa_q == REG_CTRL || awa_q == REG_PTR || awa_q == REG_SP
					|| awa_q == REG_CMD || awa_q == REG_RES) begin
				br_d = RESP_OKAY;
			end else begin
				br_d = RESP_SLVERR;
			end
		end else if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		awr_d = !awv_d;
		wr_d = !wv_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awv_q <= 1'b0;
			awa_q <= BYTE_RST;
			wv_q <= 1'b0;
			wd_q <= '0;
			ws_q <= NIB_RST;
			bv_q <= 1'b0;
			br_q <= RESP_OKAY;
			awr_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			awv_q <= awv_d;
			awa_q <= awa_d;
			wv_q <= wv_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			br_q <= br_d;
			awr_q <= awr_d;
			wr_q <= wr_d;
		end
	end

	// Read channel: data sampled at the address handshake
	always_comb begin
		arr_d = arr_q;
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (s_axi_arvalid && arr_q) begin
			arr_d = 1'b0;
			rv_d = 1'b1;
			rd_d = '0;
			rr_d = RESP_OKAY;
			if (s_axi_araddr == REG_CTRL) begin
				rd_d[CTRL_BE_POS] = be_q;
				rd_d[CTRL_BS_POS +: 4] = bs_q;
				rd_d[CTRL_SBS_POS +: 2] = sbs_q;
			end else if (s_axi_araddr == REG_PTR) begin
				rd_d[PTR_L_POS +: 4] = l_q;
				rd_d[PTR_H_POS +: 4] = h_q;
				rd_d[PTR_E_POS +: 4] = e_q;
				rd_d[PTR_D_POS +: 4] = d_q;
			end else if (s_axi_araddr == REG_SP) begin
				rd_d[7:0] = sp_q;
			end else if (s_axi_araddr == REG_CMD) begin
				rd_d[CMD_MODE_POS +: 4] = mode_q;
				rd_d[CMD_OP_POS +: 8] = op_q;
				rd_d[CMD_BIT_POS +: 2] = bitn_q;
				rd_d[CMD_INS_POS +: 4] = ins_q;
			end else if (s_axi_araddr == REG_RES) begin
				rd_d[ADDR_W-1:0] = mem_addr_q;
				rd_d[RES_BIT_POS +: 2] = mem_bit_q;
				rd_d[RES_PAIR_POS] = mem_pair_q;
				rd_d[RES_RAM_POS] = ram_sel_q;
				rd_d[RES_PER_POS] = periph_sel_q;
				rd_d[RES_ERR_POS] = mem_err_q;
				rd_d[RES_DONE_POS] = done_q;
			end else begin
				rr_d = RESP_SLVERR;
			end
		end else if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
			arr_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arr_q <= 1'b0;
			rv_q <= 1'b0;
			rd_q <= '0;
			rr_q <= RESP_OKAY;
		end else begin
			arr_q <= arr_d || (!rv_d && !arr_q && !rv_q);
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
		end
	end

	// Bank, pointer and command registers; a command write starts one access
	always_comb begin
		be_d = be_q;
		bs_d = bs_q;
		sbs_d = sbs_q;
		l_d = l_q;
		h_d = h_q;
		e_d = e_q;
		d_d = d_q;
		sp_d = sp_q;
		mode_d = mode_q;
		op_d = op_q;
		bitn_d = bitn_q;
		ins_d = ins_q;
		go_d = 1'b0;
		if (do_wr && awa_q == REG_CTRL) begin
			if (lane(ws_q, CTRL_BE_POS)) be_d = wd_q[CTRL_BE_POS];
			// Illegal bank values are dropped, the old bank stays
			if (lane(ws_q, CTRL_BS_POS) && bank_ok(wd_q[CTRL_BS_POS +: 4])) begin
				bs_d = wd_q[CTRL_BS_POS +: 4];
			end
			if (lane(ws_q, CTRL_SBS_POS)) sbs_d = wd_q[CTRL_SBS_POS +: 2];
		end else if (do_wr && awa_q == REG_PTR) begin
			if (lane(ws_q, PTR_L_POS)) l_d = wd_q[PTR_L_POS +: 4];
			if (lane(ws_q, PTR_H_POS)) h_d = wd_q[PTR_H_POS +: 4];
			if (lane(ws_q, PTR_E_POS)) e_d = wd_q[PTR_E_POS +: 4];
			if (lane(ws_q, PTR_D_POS)) d_d = wd_q[PTR_D_POS +: 4];
		end else if (do_wr && awa_q == REG_SP) begin
			if (lane(ws_q, 0)) sp_d = wd_q[7:0];
		end else if (do_wr && awa_q == REG_CMD) begin
			mode_d = dmag_mode_t'(wd_q[CMD_MODE_POS +: 4]);
			op_d = wd_q[CMD_OP_POS +: 8];
			bitn_d = wd_q[CMD_BIT_POS +: 2];
			ins_d = dmag_instr_t'(wd_q[CMD_INS_POS +: 4]);
			go_d = 1'b1;
		end
		// Step after the address used the old bottom nibble
		if (go_q && mode_q == MODE_HL_INC) l_d = l_q + 4'h1;
		else if (go_q && mode_q == MODE_HL_DEC) l_d = l_q - 4'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			be_q <= 1'b0;
			bs_q <= BANK_LOW;
			sbs_q <= 2'b00;
			l_q <= NIB_RST;
			h_q <= NIB_RST;
			e_q <= NIB_RST;
			d_q <= NIB_RST;
			sp_q <= BYTE_RST;
			mode_q <= MODE_DIR4;
			op_q <= BYTE_RST;
			bitn_q <= 2'b00;
			ins_q <= INS_MOV;
			go_q <= 1'b0;
		end else begin
			be_q <= be_d;
			bs_q <= bs_d;
			sbs_q <= sbs_d;
			l_q <= l_d;
			h_q <= h_d;
			e_q <= e_d;
			d_q <= d_d;
			sp_q <= sp_d;
			mode_q <= mode_d;
			op_q <= op_d;
			bitn_q <= bitn_d;
			ins_q <= ins_d;
			go_q <= go_d;
		end
	end

	// Access result; refused requests raise the error and no strobe
	always_comb begin
		ma_d = mem_addr_q;
		mo_d = mem_addr_odd_q;
		mb_d = mem_bit_q;
		mp_d = mem_pair_q;
		rs_d = ram_sel_q;
		ps_d = periph_sel_q;
		me_d = mem_err_q;
		ms_d = 1'b0;
		done_d = done_q;
		if (go_q) begin
			ma_d = cif.addr;
			mo_d = cif.addr | ADDR_ODD;
			mb_d = cif.bitsel;
			mp_d = cif.pair;
			rs_d = ram_hit && !cif.bad;
			ps_d = per_hit && !cif.bad;
			me_d = cif.bad;
			ms_d = !cif.bad;
			done_d = 1'b1;
		end else if (do_wr && awa_q == REG_CMD) begin
			done_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_addr_q <= '0;
			mem_addr_odd_q <= '0;
			mem_bit_q <= 2'b00;
			mem_pair_q <= 1'b0;
			ram_sel_q <= 1'b0;
			periph_sel_q <= 1'b0;
			mem_err_q <= 1'b0;
			mem_strobe_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			mem_addr_q <= ma_d;
			mem_addr_odd_q <= mo_d;
			mem_bit_q <= mb_d;
			mem_pair_q <= mp_d;
			ram_sel_q <= rs_d;
			periph_sel_q <= ps_d;
			mem_err_q <= me_d;
			mem_strobe_q <= ms_d;
			done_q <= done_d;
		end
	end

	assign s_axi_awready = awr_q;
	assign s_axi_wready = wr_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rr_q;

	// Checks on the address path
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_cmd;
		do_wr && awa_q == REG_CMD;
	endsequence
	sequence s_access;
		go_q ##1 (mem_strobe_q || mem_err_q);
	endsequence
	logic dir_go;
	assign dir_go = go_q && mode_q inside {MODE_DIR1, MODE_DIR4, MODE_DIR8};
	AST_CMD_FLOW: assert property (s_cmd |=> s_access)
		else $error("command did not produce an access");
	AST_BANK_LOW: assert property (dir_go && !be_q && !op_q[7]
		|=> mem_addr_q[ADDR_W-1 -: BANK_W] == BANK_LOW)
		else $error("low operand not in bank 0");
	AST_BANK_HIGH: assert property (dir_go && !be_q && op_q[7]
		|=> mem_addr_q[ADDR_W-1 -: BANK_W] == BANK_PERIPH)
		else $error("high operand not in bank 15");
	AST_BANK_SEL: assert property (dir_go && be_q
		|=> mem_addr_q[ADDR_W-1 -: BANK_W] == $past(bs_q))
		else $error("direct bank not from select register");
	AST_DIR1_INS: assert property (go_q && mode_q == MODE_DIR1 && ins_q == INS_MOV
		|=> mem_err_q && !mem_strobe_q)
		else $error("1-bit direct taken by wrong instruction");
	AST_DIR8_INS: assert property (go_q && mode_q == MODE_DIR8 && ins_q == INS_INCREMENT_SKIP_INSTR
		|=> mem_err_q && !mem_strobe_q)
		else $error("8-bit direct taken by wrong instruction");
	AST_POST_STEP: assert property (go_q && mode_q == MODE_HL_INC
		|=> l_q == 4'($past(l_q) + 4'h1) && mem_addr_q[3:0] == $past(l_q))
		else $error("pointer step wrong or too early");
	AST_BANK_ZERO: assert property (go_q && mode_q inside {MODE_DE, MODE_DL}
		|=> mem_addr_q[ADDR_W-1 -: BANK_W] == BANK_LOW)
		else $error("second or third pointer left bank 0");
	AST_PAIR: assert property (mem_strobe_q && mem_pair_q
		|-> !mem_addr_q[0] && mem_addr_odd_q == 12'(mem_addr_q + ADDR_ODD))
		else $error("byte access not an even-odd pair");
	AST_STACK: assert property (go_q && mode_q == MODE_STACK
		|=> mem_addr_q[ADDR_W-1 -: 2] == 2'b00 && mem_addr_q[7:0] == $past(sp_q))
		else $error("stack address outside banks 0 to 3");
	AST_BANK_LEGAL: assert property (bank_ok(bs_q))
		else $error("bank select holds an illegal value");
	AST_REGION: assert property (mem_strobe_q && ram_sel_q |-> mem_addr_q <= RAM_TOP)
		else $error("RAM select outside RAM");
	AST_WR_RESP: assert property (do_wr |=> s_axi_bvalid ##0 !awv_q)
		else $error("write response missing");
endmodule
`default_nettype wire

// ==== dmag_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmag_mem_model (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Access from the generator
	input  wire logic [11:0] addr,
	input  wire logic [11:0] addr_odd,
	input  wire logic [1:0]  bitn,
	input  wire logic        pair,
	input  wire logic        strobe,
	input  wire logic        ram_sel,
	input  wire logic        per_sel,
	// Last access taken and access count
	output logic [31:0]      cap,
	output logic [15:0]      cnt
);
	// Memory only looks at the address lines in the strobe cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap <= 32'h0;
			cnt <= 16'h0;
		end else if (strobe) begin
			cap <= {3'h0, per_sel, ram_sel, pair, bitn, addr_odd, addr};
			cnt <= cnt + 16'h1;
		end
	end
endmodule
`default_nettype wire

// ==== data_memory_address_gen_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module data_memory_address_gen_tb import dmag_pkg::*;;
	// Row: ctrl {sbs,bs,be}, ptr {D,E,H,L}, sp, cmd {ins,bit,op,mode}, addr, {bit,pair,err}
	typedef struct packed {
		logic [11:0] ctrl;
		logic [15:0] ptr;
		logic [7:0]  sp;
		logic [19:0] cmd;
		logic [11:0] addr;
		logic [3:0]  res;
	} dmag_row_t;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, cap;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, mbit;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [11:0] maddr, modd;
	logic        mpair, mstb, ramsel, persel, merr;
	logic [15:0] cnt;
	int          n_errors, check_count;
	dmag_row_t   rows[$];

	dmag_top u_dmag_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_addr_q(maddr),
		.mem_addr_odd_q(modd), .mem_bit_q(mbit), .mem_pair_q(mpair),
		.mem_strobe_q(mstb), .ram_sel_q(ramsel), .periph_sel_q(persel),
		.mem_err_q(merr));

	dmag_mem_model u_dmag_mem_model (.aclk(aclk), .aresetn(aresetn), .addr(maddr),
		.addr_odd(modd), .bitn(mbit), .pair(mpair), .strobe(mstb), .ram_sel(ramsel),
		.per_sel(persel), .cap(cap), .cnt(cnt));

	// 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic give_verdict;
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Handshakes are judged on values settled before the edge that takes them
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hs, w_hs, b_hs;
		int   n;
		b_hs = 1'b0;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hs && n < 50) begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bvalid && bready;
			if (b_hs) chk("bresp", {30'h0, er}, {30'h0, bresp});
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (b_hs) bready <= 1'b0;
			n++;
		end
		if (!b_hs) chk("write_wait", 32'h0, 32'h1);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic ar_hs, r_hs;
		int   n;
		r_hs = 1'b0;
		n = 0;
		d = 32'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hs && n < 50) begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs = rvalid && rready;
			if (r_hs) d = rdata;
			if (r_hs) chk("rresp", {30'h0, er}, {30'h0, rresp});
			@(posedge aclk);
			if (ar_hs) arvalid <= 1'b0;
			if (r_hs) rready <= 1'b0;
			n++;
		end
		if (!r_hs) chk("read_wait", 32'h0, 32'h1);
	endtask

	// One access: load context, issue command, compare memory side and result
	task automatic run(input dmag_row_t r);
		logic [31:0] d;
		logic [15:0] c0;
		logic        ram, per;
		axi_wr(REG_CTRL, {20'h0, r.ctrl}, RESP_OKAY);
		axi_wr(REG_PTR, {16'h0, r.ptr}, RESP_OKAY);
		axi_wr(REG_SP, {24'h0, r.sp}, RESP_OKAY);
		c0 = cnt;
		axi_wr(REG_CMD, {12'h0, r.cmd}, RESP_OKAY);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		ram = (r.addr <= RAM_TOP);
		per = (r.addr >= PERIPH_BASE);
		chk("refused", {31'h0, r.res[0]}, {31'h0, merr});
		chk("strobes", {16'h0, c0 + {15'h0, ~r.res[0]}}, {16'h0, cnt});
		if (r.res[0]) begin
			chk("sels", 32'h0, {30'h0, ramsel, persel});
		end else begin
			chk("access", {3'h0, per, ram, r.res[1], r.res[3:2], r.addr | ADDR_ODD, r.addr}, cap);
			axi_rd(REG_RES, d, RESP_OKAY);
			chk("result", {14'h1, 1'b0, per, ram, r.res[1], r.res[3:2], r.addr}, d);
		end
	endtask

	// Outputs and registers after a reset
	task automatic reset_chk;
		logic [31:0] d;
		chk("rst_out", 32'h0, {1'b0, maddr, modd, mbit, mpair, mstb, ramsel, persel, merr});
		for (int i = 0; i < 5; i++) begin
			if (i != 3) axi_rd(8'(i * 4), d, RESP_OKAY);
			if (i != 3) chk("rst_reg", 32'h0, d);
		end
	endtask

	// Watchdog: whole run is under two thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		give_verdict();
	end

	initial begin
		logic [31:0] d;
		logic [7:0]  cur;
		logic [3:0]  ins;
		logic        ok;
		{aresetn, awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
		n_errors = 0;
		check_count = 0;
		rows.push_back({12'h020, 16'h0, 8'h0, 20'h407f1, 12'h07f, 4'h0});
		rows.push_back({12'h020, 16'h0, 8'h0, 20'h70801, 12'hf80, 4'h0});
		rows.push_back({12'h021, 16'h0, 8'h0, 20'h80801, 12'h280, 4'h0});
		rows.push_back({12'h0f1, 16'h0, 8'h0, 20'h407f1, 12'hf7f, 4'h0});
		rows.push_back({12'h031, 16'h0, 8'h0, 20'h50ff1, 12'h3ff, 4'h0});
		rows.push_back({12'h020, 16'h0, 8'h0, 20'h013f0, 12'h03f, 4'h4});
		rows.push_back({12'h000, 16'h0, 8'h0, 20'h30a70, 12'hfa7, 4'h0});
		rows.push_back({12'h000, 16'h0, 8'h0, 20'h50202, 12'h020, 4'h2});
		rows.push_back({12'h000, 16'h0, 8'h0, 20'h40212, 12'h021, 4'h1});
		rows.push_back({12'h011, 16'h0, 8'h0, 20'h80fe2, 12'h1fe, 4'h2});
		rows.push_back({12'h031, 16'h0017, 8'h0, 20'hf0003, 12'h317, 4'h0});
		rows.push_back({12'h030, 16'h0017, 8'h0, 20'hf0003, 12'h017, 4'h0});
		rows.push_back({12'h031, 16'h5700, 8'h0, 20'hf0006, 12'h057, 4'h0});
		rows.push_back({12'h031, 16'h5007, 8'h0, 20'hf0007, 12'h057, 4'h0});
		rows.push_back({12'h011, 16'h0031, 8'h0, 20'hf0008, 12'h130, 4'h2});
		rows.push_back({12'h031, 16'h0, 8'h0, 20'hf3b29, 12'hfb2, 4'hc});
		rows.push_back({12'h031, 16'h0, 8'h0, 20'hf2f59, 12'hff5, 4'h8});
		rows.push_back({12'h031, 16'h0, 8'h0, 20'hf0c09, 12'hfc0, 4'h1});
		rows.push_back({12'h031, 16'h000b, 8'h0, 20'hf0fda, 12'hffe, 4'hc});
		rows.push_back({12'h031, 16'h000b, 8'h0, 20'hf080a, 12'hf80, 4'h1});
		rows.push_back({12'h0f1, 16'h00a0, 8'h0, 20'hf235b, 12'hfa5, 4'h8});
		rows.push_back({12'h0f0, 16'h00a0, 8'h0, 20'hf135b, 12'h0a5, 4'h4});
		rows.push_back({12'h200, 16'h0, 8'hc4, 20'hf000c, 12'h2c4, 4'h0});
		rows.push_back({12'h000, 16'h0, 8'h0, 20'hf000d, 12'h000, 4'h1});
		rows.push_back({12'h000, 16'h0, 8'h0, 20'hf000f, 12'h000, 4'h1});
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		reset_chk();
		foreach (rows[i]) run(rows[i]);
		// Every instruction code against each direct mode
		for (int m = 0; m < 3; m++) begin
			for (int i = 0; i < 10; i++) begin
				ins = (i == 9) ? 4'hf : 4'(i);
				ok = (m == 0) ? (ins <= 4'h3) : (m == 1) ? (ins inside {[4'h4 : 4'h8]}) :
					(ins inside {4'h4, 4'h5, 4'h7, 4'h8});
				run({12'h0, 16'h0, 8'h0, ins, 4'h0, 8'h40, 4'(m), 12'h040, 2'h0, m == 2, !ok});
			end
		end
		// Pointer steps after use and wraps within the bottom nibble
		run({12'h031, 16'h001f, 8'h0, 20'hf0004, 12'h31f, 4'h0});
		axi_rd(REG_PTR, d, RESP_OKAY);
		chk("ptr_inc", 32'h10, d);
		run({12'h031, 16'h0010, 8'h0, 20'hf0005, 12'h310, 4'h0});
		axi_rd(REG_PTR, d, RESP_OKAY);
		chk("ptr_dec", 32'h1f, d);
		// Bank select keeps its value on an illegal write
		cur = 8'h01;
		for (int b = 0; b < 16; b++) begin
			axi_wr(REG_CTRL, {24'h0, 4'(b), 4'h1}, RESP_OKAY);
			if (b <= 3 || b == 15) cur = {4'(b), 4'h1};
			axi_rd(REG_CTRL, d, RESP_OKAY);
			chk("bank_sel", {24'h0, cur}, d);
		end
		axi_wr(8'h14, 32'h1, RESP_SLVERR);
		axi_rd(8'h14, d, RESP_SLVERR);
		chk("unmapped", 32'h0, d);
		// Second reset in mid-run
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		reset_chk();
		give_verdict();
	end
endmodule
`default_nettype wire
